// ### gp_port.v
`timescale 1ns/100ps
`default_nettype none
`include "gp_regs.vh"

module gp_port #(
  parameter NPINS     = 25,
  parameter XBAR_PINS = 23
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // wishbone slave
  input  wire             cyc_i,
  input  wire             stb_i,
  input  wire             we_i,
  input  wire [7:0]       adr_i,
  input  wire [3:0]       sel_i,
  input  wire [31:0]      dat_i,
  output reg  [31:0]      dat_o,
  output wire             ack_o,
  // pads
  input  wire [NPINS-1:0] pad_i,
  output reg  [NPINS-1:0] pad_o,
  output reg  [NPINS-1:0] pad_oe_o,
  output reg  [NPINS-1:0] pullup_o,
  // crossbar peripheral side
  input  wire [NPINS-1:0] xbar_claim_i,
  input  wire [NPINS-1:0] xbar_dat_i,
  output reg  [NPINS-1:0] xbar_claimed_o,
  output reg  [NPINS-1:0] xbar_in_o,
  // primary uart
  input  wire             uart_tx_i,
  output reg              uart_rx_o,
  // interrupt
  output reg              irq_o
);

  // configuration state
  reg [NPINS-1:0]       pin_input_mode_bits;
  reg [NPINS-1:0]       pin_output_drive_bits;
  reg [NPINS-1:0]       crossbar_skip_bits;
  reg [NPINS-1:0]       out_val;
  reg [NPINS-1:0]       ev_stat;
  reg [NPINS-1:0]       ev_en;
  reg [NPINS-1:0]       pad_prev;
  reg                   crossbar_enable_bit;
  reg                   pullup_global_disable;
  reg                   primary_uart;
  reg [1:0]             osc_mode;
  reg                   ack;

  // per-pin combinational results
  wire [NPINS-1:0]      digital;
  wire [NPINS-1:0]      elig;
  wire [NPINS-1:0]      claimed;
  wire [NPINS-1:0]      next_pad_o;
  wire [NPINS-1:0]      next_oe;
  wire [NPINS-1:0]      next_pullup;
  wire [NPINS-1:0]      pin_read;
  wire [NPINS-1:0]      ev_hit;
  wire [NPINS-1:0]      ev_clr;

  wire wr = cyc_i & stb_i & we_i & ~ack;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : gp_pin
      // oscillator pins are forced analog whatever the mode bits say
      wire osc_pin = ((osc_mode == `GP_OSC_XTAL) &&
                      (g == `GP_PIN_OSC_IN || g == `GP_PIN_OSC_OUT)) ||
                     ((osc_mode == `GP_OSC_RC) && (g == `GP_PIN_OSC_OUT)); // [RL17]
      wire uart_tx = primary_uart && (g == `GP_PIN_UART_TX);               // [RL14]
      wire uart_rx = primary_uart && (g == `GP_PIN_UART_RX);               // [RL14]
      wire val;
      wire drv;
      // mode bit 1 is digital, oscillator use overrides
      assign digital[g] = pin_input_mode_bits[g] & ~osc_pin;                 // [RL18] [RL2]
      // fixed uart pins are taken out of the priority pool
      assign elig[g] = (g < XBAR_PINS) & ~crossbar_skip_bits[g] &
                       ~uart_tx & ~uart_rx;                                  // [RL13] [RL11]
      assign claimed[g] = crossbar_enable_bit & digital[g] &
                          (uart_tx | uart_rx | (xbar_claim_i[g] & elig[g]));
      assign val = uart_tx ? uart_tx_i : (claimed[g] ? xbar_dat_i[g] : out_val[g]);
      // nothing drives while the crossbar is off or the pin is analog / rx
      assign drv = crossbar_enable_bit & digital[g] & ~uart_rx;             // [RL19] [RL1] [RL2]
      assign next_oe[g] = drv & (pin_output_drive_bits[g] | ~val);          // [RL5] [RL6]
      assign next_pad_o[g] = pin_output_drive_bits[g] ? val : 1'b0;         // [RL6]
      // pull-up on when released, off when driving or disabled globally
      assign next_pullup[g] = digital[g] & ~pullup_global_disable &
                              ~next_oe[g];                                   // [RL7] [RL8] [RL9]
      // analog receivers are off and read as zero
      assign pin_read[g] = digital[g] & pad_i[g];                            // [RL3] [RL10]
      // edge on any digital pin, skipped or claimed
      assign ev_hit[g] = digital[g] & (pad_i[g] ^ pad_prev[g]);             // [RL15] [RL16]
    end
  endgenerate

  assign ev_clr = (wr && adr_i == `GP_ADR_EVCLR) ? (dat_i[NPINS-1:0] & wmask[NPINS-1:0])
                                                 : {NPINS{1'b0}};

  // register writes and reset state
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_input_mode_bits   <= {NPINS{1'b1}};                                // [RL18]
      pin_output_drive_bits <= {NPINS{1'b0}};
      crossbar_skip_bits    <= {NPINS{1'b0}};
      out_val               <= {NPINS{1'b1}};
      ev_en                 <= {NPINS{1'b0}};
      crossbar_enable_bit   <= 1'b0;                                         // [RL1]
      pullup_global_disable <= 1'b0;
      primary_uart          <= 1'b0;
      osc_mode              <= `GP_OSC_OFF;
    end else if (wr) begin
      case (adr_i)
        `GP_ADR_INMODE:
          pin_input_mode_bits <= (pin_input_mode_bits & ~wmask[NPINS-1:0]) |
                                 (dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
        `GP_ADR_OUTDRV:
          pin_output_drive_bits <= (pin_output_drive_bits & ~wmask[NPINS-1:0]) |
                                   (dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
        `GP_ADR_SKIP:
          crossbar_skip_bits <= (crossbar_skip_bits & ~wmask[NPINS-1:0]) |
                                (dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
        `GP_ADR_OUTVAL:
          out_val <= (out_val & ~wmask[NPINS-1:0]) | (dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
        `GP_ADR_EVEN:
          ev_en <= (ev_en & ~wmask[NPINS-1:0]) | (dat_i[NPINS-1:0] & wmask[NPINS-1:0]);
        `GP_ADR_CTRL: begin
          if (sel_i[0]) begin
            crossbar_enable_bit   <= dat_i[`GP_CTRL_XBE];
            pullup_global_disable <= dat_i[`GP_CTRL_PUD];
            primary_uart          <= dat_i[`GP_CTRL_UART];
            osc_mode              <= dat_i[`GP_CTRL_OSC_H:`GP_CTRL_OSC_L];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // sticky events: a new edge wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat  <= {NPINS{1'b0}};
      pad_prev <= {NPINS{1'b1}};
      irq_o    <= 1'b0;
    end else begin
      pad_prev <= pad_i;
      ev_stat  <= (ev_stat & ~ev_clr) | ev_hit;                              // [RL15]
      irq_o    <= |(((ev_stat & ~ev_clr) | ev_hit) & ev_en);
    end
  end

  // pad and peripheral outputs, registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_o          <= {NPINS{1'b0}};
      pad_oe_o       <= {NPINS{1'b0}};                                       // [RL1]
      pullup_o       <= {NPINS{1'b1}};                                       // [RL1]
      xbar_claimed_o <= {NPINS{1'b0}};
      xbar_in_o      <= {NPINS{1'b0}};
      uart_rx_o      <= 1'b1;
    end else begin
      pad_o          <= next_pad_o;
      pad_oe_o       <= next_oe;
      pullup_o       <= next_pullup;
      xbar_claimed_o <= claimed;
      xbar_in_o      <= pin_read;
      uart_rx_o      <= primary_uart ? pin_read[`GP_PIN_UART_RX] : 1'b1;     // [RL14]
    end
  end

  // wishbone: one wait state, unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack   <= cyc_i & stb_i & ~ack;
      dat_o <= 32'h0000_0000;
      if (cyc_i & stb_i & ~we_i & ~ack) begin
        case (adr_i)
          `GP_ADR_INMODE: dat_o[NPINS-1:0] <= pin_input_mode_bits;
          `GP_ADR_OUTDRV: dat_o[NPINS-1:0] <= pin_output_drive_bits;
          `GP_ADR_SKIP:   dat_o[NPINS-1:0] <= crossbar_skip_bits;
          `GP_ADR_OUTVAL: dat_o[NPINS-1:0] <= out_val;
          `GP_ADR_PINS:   dat_o[NPINS-1:0] <= pin_read;                      // [RL3] [RL10]
          `GP_ADR_EVSTAT: dat_o[NPINS-1:0] <= ev_stat;
          `GP_ADR_EVEN:   dat_o[NPINS-1:0] <= ev_en;
          `GP_ADR_ELIG:   dat_o[NPINS-1:0] <= elig;
          `GP_ADR_CTRL:   dat_o[`GP_CTRL_W-1:0] <= {osc_mode, primary_uart,
                                                    pullup_global_disable,
                                                    crossbar_enable_bit};
          default:        dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign ack_o = ack;

endmodule // gp_port

`default_nettype wire

// ### gp_regs.vh
// Contract
// RL1 - after reset pads float with pull-ups on until crossbar is enabled
// RL2 - analog pin turns off pull-up, output driver and input receiver
// RL3 - reading an analog pin returns 0 regardless of pad level
// RL4 - software puts comparator, converter, oscillator, reference pins in analog mode
// RL5 - output-mode bit 1 gives push-pull drive of the output value
// RL6 - open-drain never drives high, pulls low for 0, releases for 1
// RL7 - a digital pin not being driven gets its weak pull-up
// RL8 - pull-up is off while the cell drives its pad low
// RL9 - global pull-up disable bit 1 turns off every pull-up
// RL10 - reading a digital pin returns the sensed pad level
// RL11 - analog pins are skipped by software and never claimed by crossbar
// RL12 - software skips bypass-function pins and general-purpose pins
// RL13 - only unskipped pins P0.0 to P2.6 may go to crossbar peripherals
// RL14 - enabled primary uart always sits on P0.4 and P0.5
// RL15 - pad transitions raise event flags on skipped and crossbar pins alike
// RL16 - no event capture on pins in analog mode
// RL17 - oscillator uses P0.2 and P0.3 for crystal, only P0.3 for rc or c
// RL18 - input mode bit 1 is digital, 0 analog; reset gives digital
// RL19 - with crossbar disabled all output drivers stay off
`ifndef GP_REGS_VH
`define GP_REGS_VH

// register byte offsets
`define GP_ADR_INMODE 8'h00
`define GP_ADR_OUTDRV 8'h04
`define GP_ADR_SKIP   8'h08
`define GP_ADR_CTRL   8'h0c
`define GP_ADR_OUTVAL 8'h10
`define GP_ADR_PINS   8'h14
`define GP_ADR_EVSTAT 8'h18
`define GP_ADR_EVCLR  8'h1c
`define GP_ADR_EVEN   8'h20
`define GP_ADR_ELIG   8'h24

// control register fields
`define GP_CTRL_XBE   0
`define GP_CTRL_PUD   1
`define GP_CTRL_UART  2
`define GP_CTRL_OSC_L 3
`define GP_CTRL_OSC_H 4
`define GP_CTRL_W     5

// oscillator pin modes
`define GP_OSC_OFF    2'h0
`define GP_OSC_XTAL   2'h1
`define GP_OSC_RC     2'h2

// fixed pin positions
`define GP_PIN_OSC_IN  2
`define GP_PIN_OSC_OUT 3
`define GP_PIN_UART_TX 4
`define GP_PIN_UART_RX 5

`endif

// ### gp_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module gp_port_props #(parameter NPINS = 25, parameter XBAR_PINS = 23) (
  // bus side
  input wire logic             clk_i, rst_i, cyc_i, stb_i, ack_o, irq_o,
  input wire logic [31:0]      dat_o,
  // pads and crossbar
  input wire logic [NPINS-1:0] pad_i, pad_oe_o, pullup_o,
  input wire logic [NPINS-1:0] xbar_claim_i, xbar_claimed_o, xbar_in_o
);
  // uart pins are placed by hardware, never by a claim
  localparam [NPINS-1:0] UPINS = 25'h30;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_pulse;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_answer: assert property (s_req |=> s_pulse) else $error("no single ack");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("stray ack");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
  a_reset_safe: assert property (disable iff (1'b0)
    $fell(rst_i) |-> !pad_oe_o && &pullup_o && !irq_o) else $error("pads unsafe at reset");
  a_drive_pull: assert property ((pad_oe_o & pullup_o) == '0)
    else $error("pull-up on a driven pad");
  a_claim_range: assert property ((xbar_claimed_o >> XBAR_PINS) == '0)
    else $error("claim above crossbar range");
  a_claim_cause: assert property ((xbar_claimed_o & ~$past(xbar_claim_i) & ~UPINS) == '0)
    else $error("pin claimed unasked");
  a_read_pad: assert property ((xbar_in_o & ~$past(pad_i)) == '0)
    else $error("read high on low pad");
endmodule // gp_port_props
`default_nettype wire

// ### gp_pads.sv
`timescale 1ns/100ps
`default_nettype none
module gp_pads #(parameter NPINS = 25) (
  // cell drive and outside circuit level
  input  wire logic [NPINS-1:0] oe_i, lvl_i, ext_i,
  // resolved pad level
  output logic      [NPINS-1:0] lvl_o
);
  // outside circuit holds every pad the cell does not drive, so none floats
  assign lvl_o = (oe_i & lvl_i) | (~oe_i & ext_i);
endmodule // gp_pads
`default_nettype wire

// ### test_gp_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_gp_port;
  // ports, then model state
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, uart_rx_o, irq_o;
  logic [7:0]  adr_i = 8'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'd80376;
  logic [24:0] pad_i, pad_o, pad_oe_o, pullup_o, xbar_claimed_o, xbar_in_o, t, im, od, ov, sk;
  logic [24:0] xbar_claim_i = 25'h0, xbar_dat_i = 25'h0, ext = 25'h1ffffff, dg, cl, eoe, eo, pl;
  logic [4:0]  ct;
  integer      n_mismatch = 0, total_checks = 0, k, n;
  always #5 clk_i = ~clk_i;
  gp_port gp_port_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o,
    .ack_o, .pad_i, .pad_o, .pad_oe_o, .pullup_o, .xbar_claim_i, .xbar_dat_i, .xbar_claimed_o,
    .xbar_in_o, .uart_tx_i(1'b0), .uart_rx_o, .irq_o);
  gp_pads gp_pads_i (.oe_i(pad_oe_o), .lvl_i(pad_o), .ext_i(ext), .lvl_o(pad_i));
  function automatic logic [24:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[24:0];
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one classic cycle held until ack; read data taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin n_mismatch++; finish_test; end
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  // pads lag config by a register and reads by one more
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // expected pads worked out from the configuration
  task automatic model;
    dg = im & ~(ct[4:3] == 2'h1 ? 25'hc : ct[4:3] == 2'h2 ? 25'h8 : 25'h0);
    cl = xbar_claim_i & ~sk & 25'h7fffff;
    eo = (cl & xbar_dat_i) | (~cl & ov);
    eoe = {25{ct[0]}} & dg & (od | ~eo);
    eo = od & eo;
    pl = (eoe & eo) | (~eoe & ext);
  endtask
  // reset, random pad configs, events, uart placement
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    chk(32'(pullup_o), 32'h1ffffff);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1ffffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h04, 32'h1ffffff);
    wb(1'b1, 8'h10, 32'h0);
    settle;
    chk(32'(pad_oe_o), 32'h0);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      t = rnd();
      ct = {t[4:3], 1'b0, t[1], 1'b1};
      im = rnd();
      sk = rnd() | ~im;
      od = rnd() & ~25'h20;
      ov = rnd() | 25'h20;
      wb(1'b1, 8'h00, 32'(im));
      wb(1'b1, 8'h04, 32'(od));
      wb(1'b1, 8'h08, 32'(sk));
      wb(1'b1, 8'h10, 32'(ov));
      wb(1'b1, 8'h0c, 32'(ct));
      model;
      @(posedge clk_i);
      xbar_claim_i <= rnd() & dg & ~25'h30;
      xbar_dat_i <= rnd();
      ext <= rnd();
      settle;
      model;
      chk(32'(xbar_claimed_o), 32'(cl));
      chk(32'(pad_oe_o), 32'(eoe));
      chk(32'(pad_o), 32'(eo));
      chk(32'(pullup_o), 32'(~eoe & dg & {25{~ct[1]}}));
      chk(32'(xbar_in_o), 32'(dg & pl));
      wb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'(dg & pl));
    end
    $display("pad test done");
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b1, 8'h00, 32'h1fffdff);
    @(posedge clk_i);
    ext <= 25'h1ffffff;
    settle;
    wb(1'b1, 8'h1c, 32'h1ffffff);
    wb(1'b1, 8'h20, 32'h80);
    @(posedge clk_i);
    ext <= 25'h1fffc7f;
    settle;
    chk(32'(irq_o), 32'h1);
    wb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h180);
    wb(1'b1, 8'h20, 32'h0);
    settle;
    chk(32'(irq_o), 32'h0);
    wb(1'b1, 8'h1c, 32'h180);
    wb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    $display("event test done");
    wb(1'b1, 8'h0c, 32'h5);
    settle;
    chk(32'(xbar_claimed_o & 25'h30), 32'h30);
    chk(32'(pad_oe_o[5]), 32'h0);
    chk(32'(pad_oe_o[4]), 32'h1);
    chk(32'(pad_o[4]), 32'h0);
    chk(32'(uart_rx_o), 32'h1);
    @(posedge clk_i);
    ext <= 25'h1fffc5f;
    settle;
    chk(32'(uart_rx_o), 32'h0);
    $display("uart test done");
    finish_test;
  end
endmodule // test_gp_port
bind gp_port gp_port_props #(.NPINS(NPINS), .XBAR_PINS(XBAR_PINS)) gp_port_props_i (.clk_i,
  .rst_i, .cyc_i, .stb_i, .ack_o, .irq_o, .dat_o, .pad_i, .pad_oe_o, .pullup_o, .xbar_claim_i,
  .xbar_claimed_o, .xbar_in_o);
`default_nettype wire
